// ===== rtl/kpsd_pkg.sv
package kpsd_pkg;

  localparam int unsigned ADDR_W = 16;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_RUN_SLOT_1  = 14'h0f0a;
  localparam logic [13:0] IDX_RUN_SLOT_2  = 14'h0f0b;
  localparam logic [13:0] IDX_RUN_SLOT_3  = 14'h0f0c;
  localparam logic [13:0] IDX_RUN_SLOT_4  = 14'h0f0d;
  localparam logic [13:0] IDX_RUN_SLOT_5  = 14'h0f0e;
  localparam logic [13:0] IDX_STOP_SLOT_1 = 14'h0f0f;
  localparam logic [13:0] IDX_STOP_SLOT_2 = 14'h0f10;
  localparam logic [13:0] IDX_STOP_SLOT_3 = 14'h0f11;
  localparam logic [13:0] IDX_STOP_SLOT_4 = 14'h0f12;
  localparam logic [13:0] IDX_STOP_SLOT_5 = 14'h0f13;
  localparam logic [13:0] IDX_EDIT_STATUS = 14'h0f20;

  localparam int unsigned SLOTS     = 5;
  localparam logic [3:0]  STOP_BASE = 4'h5;

  // slot reset values, slot 0 = running slot 1 ... slot 9 = stop slot 5
  localparam logic [9:0][5:0] SLOT_RESET = {6'h00, 6'h1a, 6'h14, 6'h08, 6'h03,
                                            6'h08, 6'h06, 6'h07, 6'h04, 6'h05};

  // one bit per legal item code 0..63
  localparam logic [63:0] ITEM_VALID = 64'hfe01_617f_ee1f_ffff;

  localparam logic [15:0] GROUP_STEP = 16'h0100;
  localparam logic [15:0] PARAM_STEP = 16'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {MENU_MONITOR, MENU_GROUP, MENU_PARAM, MENU_EDIT} kpsd_menu_type;

  typedef struct packed {
    logic shift;
    logic confirm;
    logic program_escape_key;
    logic up;
    logic down;
  } kpsd_keys_type;

  typedef struct packed {
    logic unchangeable;
    logic stop_only;
    logic password_active;
  } kpsd_guard_type;

  typedef struct packed {
    logic [9:0][5:0] slot;
    logic [2:0]      ptr;
    logic            run_prev;
    logic [5:0]      disp_item;
    kpsd_menu_type   menu;
    logic [15:0]     param_idx;
    logic [15:0]     pending;
    logic            blink;
    logic            commit;
    logic [15:0]     commit_idx;
    logic [15:0]     commit_val;
    logic            aw_hold;
    logic [13:0]     aw_idx;
    logic            w_hold;
    logic [15:0]     w_data;
    logic [1:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } kpsd_state_type;

  localparam kpsd_state_type STATE_RESET = '{slot: SLOT_RESET, menu: MENU_MONITOR, default: '0};

endpackage

// ===== rtl/kpsd_top.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - shift key advances to next listed quantity
// - running defaults: running, given, current, voltage, bus
// - stopped defaults: set freq, bus, analog, potentiometer
// - five running slots select items by code
// - five stopped slots share the code set
// - codes 0..13 are base quantities
// - codes 14..18 are status, temperatures, digital states
// - codes 19,20,25,26,27 are analog quantities
// - codes 29..33 pulse, separation, communication values
// - codes 34..38 PID, 40,45,46,48 extras
// - codes 57..63 times and energy halves
// - confirm commits, returns, selects next parameter
// - program key discards edit and returns
// - value blinks only when parameter is writable
// - unchangeable parameters are never edited
// - stop-only parameters refused while running
// - active password refuses panel edits
// - verify mode lists only changed parameters
module kpsd_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     clk_en,
  input  wire logic [15:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [15:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire kpsd_pkg::kpsd_keys_type  keys,
  input  wire kpsd_pkg::kpsd_guard_type guard,
  input  wire logic                     drive_running,
  input  wire logic                     verify_menu,
  input  wire logic                     param_differs,
  input  wire logic [15:0]              param_value,
  output logic [5:0]                    disp_item,
  output logic [2:0]                    disp_slot,
  output kpsd_pkg::kpsd_menu_type       menu_level,
  output logic [15:0]                   param_index,
  output logic [15:0]                   edit_value,
  output logic                          value_blink,
  output logic                          commit_pulse,
  output logic [15:0]                   commit_index,
  output logic [15:0]                   commit_value
);

  kpsd_pkg::kpsd_state_type s_q;
  kpsd_pkg::kpsd_state_type s_d;

  logic            writable;
  logic [3:0]      base;
  logic [4:0][5:0] act;
  logic            any_nz;
  logic [2:0]      next_ptr;
  logic [13:0]     ar_idx;

  // next non-empty slot after cur, wrapping; stays put when none is set
  function automatic logic [2:0] next_slot(input logic [2:0] cur, input logic [4:0][5:0] c);
    logic [2:0] r;
    logic       found;
    logic [2:0] k;
    r = cur;
    found = 1'b0;
    for (int i = 1; i <= 5; i++) begin
      k = 3'((int'(cur) + i) % 5);
      if (!found && c[k] != 6'h00) begin
        r = k;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // writes of codes outside the table leave the slot unchanged
  function automatic logic legal_code(input logic [15:0] v);
    return (v[15:6] == 10'h000) && kpsd_pkg::ITEM_VALID[v[5:0]];
  endfunction

  assign base = drive_running ? kpsd_pkg::STOP_BASE - kpsd_pkg::STOP_BASE : kpsd_pkg::STOP_BASE;

  generate
    for (genvar g = 0; g < kpsd_pkg::SLOTS; g++) begin : g_act
      assign act[g] = s_q.slot[4'(g) + base];
    end
  endgenerate

  assign any_nz   = |act;
  assign next_ptr = next_slot(s_q.ptr, act);

  // write refusal causes are checked together with the drive state
  assign writable = !guard.unchangeable
                    && !(guard.stop_only && drive_running)
                    && !guard.password_active;

  assign ar_idx = s_axi_araddr[15:2];

  always_comb begin
    logic [3:0]  widx;
    logic [15:0] wv;
    s_d  = s_q;
    widx = 4'h0;
    wv   = 16'h0000;
    s_d.commit = 1'b0;

    // display list
    if (s_q.run_prev != drive_running) begin
      s_d.ptr = next_slot(3'h4, act);
    end else if (keys.shift && s_q.menu == kpsd_pkg::MENU_MONITOR) begin
      s_d.ptr = next_ptr;
    end
    s_d.run_prev  = drive_running;
    s_d.disp_item = act[s_d.ptr];

    // menu walk
    unique case (s_q.menu)
      kpsd_pkg::MENU_MONITOR: begin
        if (keys.program_escape_key) begin
          s_d.menu = verify_menu ? kpsd_pkg::MENU_PARAM : kpsd_pkg::MENU_GROUP;
        end
      end
      kpsd_pkg::MENU_GROUP: begin
        if (verify_menu) begin
          s_d.menu = kpsd_pkg::MENU_PARAM;
        end else if (keys.program_escape_key) begin
          s_d.menu = kpsd_pkg::MENU_MONITOR;
        end else if (keys.confirm) begin
          s_d.menu = kpsd_pkg::MENU_PARAM;
        end else if (keys.up) begin
          s_d.param_idx = s_q.param_idx + kpsd_pkg::GROUP_STEP;
        end else if (keys.down) begin
          s_d.param_idx = s_q.param_idx - kpsd_pkg::GROUP_STEP;
        end
      end
      kpsd_pkg::MENU_PARAM: begin
        if (keys.program_escape_key) begin
          s_d.menu = verify_menu ? kpsd_pkg::MENU_MONITOR : kpsd_pkg::MENU_GROUP;
        end else if (verify_menu && !param_differs) begin
          // unchanged parameters are stepped over, one per cycle
          s_d.param_idx = s_q.param_idx + kpsd_pkg::PARAM_STEP;
        end else if (keys.confirm) begin
          s_d.menu    = kpsd_pkg::MENU_EDIT;
          s_d.pending = param_value;
        end else if (keys.up) begin
          s_d.param_idx = s_q.param_idx + kpsd_pkg::PARAM_STEP;
        end else if (keys.down) begin
          s_d.param_idx = s_q.param_idx - kpsd_pkg::PARAM_STEP;
        end
      end
      kpsd_pkg::MENU_EDIT: begin
        if (keys.confirm) begin
          // a refused value is not stored, but the walk still moves on
          s_d.commit     = writable;
          s_d.commit_idx = s_q.param_idx;
          s_d.commit_val = s_q.pending;
          s_d.menu       = kpsd_pkg::MENU_PARAM;
          s_d.param_idx  = s_q.param_idx + kpsd_pkg::PARAM_STEP;
        end else if (keys.program_escape_key) begin
          s_d.menu = kpsd_pkg::MENU_PARAM;
        end else if (writable && keys.up) begin
          s_d.pending = s_q.pending + 16'h0001;
        end else if (writable && keys.down) begin
          s_d.pending = s_q.pending - 16'h0001;
        end
      end
    endcase
    s_d.blink = (s_d.menu == kpsd_pkg::MENU_EDIT) && writable;

    // register bus: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_idx  = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata[15:0];
      s_d.w_strb = s_axi_wstrb[1:0];
    end
    if (s_q.aw_hold && s_q.w_hold) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = kpsd_pkg::RESP_DECERR;
      if (s_q.aw_idx >= kpsd_pkg::IDX_RUN_SLOT_1 && s_q.aw_idx <= kpsd_pkg::IDX_STOP_SLOT_5) begin
        widx = 4'(s_q.aw_idx - kpsd_pkg::IDX_RUN_SLOT_1);
        wv   = {10'h000, s_q.slot[widx]};
        if (s_q.w_strb[0]) begin
          wv[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1]) begin
          wv[15:8] = s_q.w_data[15:8];
        end
        if (legal_code(wv)) begin
          s_d.slot[widx] = wv[5:0];
          s_d.bresp      = kpsd_pkg::RESP_OKAY;
        end else begin
          s_d.bresp = kpsd_pkg::RESP_SLVERR;
        end
      end else if (s_q.aw_idx == kpsd_pkg::IDX_EDIT_STATUS) begin
        s_d.bresp = kpsd_pkg::RESP_OKAY;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = kpsd_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (ar_idx >= kpsd_pkg::IDX_RUN_SLOT_1 && ar_idx <= kpsd_pkg::IDX_STOP_SLOT_5) begin
        s_d.rdata[5:0] = s_q.slot[4'(ar_idx - kpsd_pkg::IDX_RUN_SLOT_1)];
      end else if (ar_idx == kpsd_pkg::IDX_EDIT_STATUS) begin
        s_d.rdata[15:0] = {s_q.param_idx[7:0], writable, drive_running, s_q.blink,
                           s_q.ptr, s_q.menu};
      end else begin
        s_d.rresp = kpsd_pkg::RESP_DECERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // reset wins over the clock enable so the slot defaults always load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= kpsd_pkg::STATE_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid && clk_en;
  assign s_axi_wready  = !s_q.w_hold && !s_q.bvalid && clk_en;
  assign s_axi_arready = !s_q.rvalid && clk_en;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign disp_item     = s_q.disp_item;
  assign disp_slot     = s_q.ptr;
  assign menu_level    = s_q.menu;
  assign param_index   = s_q.param_idx;
  assign edit_value    = s_q.pending;
  assign value_blink   = s_q.blink;
  assign commit_pulse  = s_q.commit;
  assign commit_index  = s_q.commit_idx;
  assign commit_value  = s_q.commit_val;

  sequence seq_edit_confirm;
    clk_en && s_q.menu == kpsd_pkg::MENU_EDIT && keys.confirm;
  endsequence

  sequence seq_edit_escape;
    clk_en && s_q.menu == kpsd_pkg::MENU_EDIT && keys.program_escape_key && !keys.confirm;
  endsequence

  sequence seq_shift_steady;
    clk_en && s_q.menu == kpsd_pkg::MENU_MONITOR && keys.shift
      && s_q.run_prev == drive_running && any_nz;
  endsequence

  a_shift_moves_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_shift_steady and (act[next_ptr] != disp_item)) |=> disp_item != $past(disp_item))
    else $error("shift did not change the shown quantity");

  a_shift_skips_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_shift_steady ##1 (!clk_en || s_q.run_prev == drive_running) |-> disp_item != 6'h00)
    else $error("shift landed on a disabled slot");

  a_run_defaults: assert property (@(posedge aclk)
    $past(!aresetn) |-> s_q.slot[4:0] == kpsd_pkg::SLOT_RESET[4:0])
    else $error("running slots lost their defaults");

  a_stop_defaults: assert property (@(posedge aclk)
    $past(!aresetn) |-> s_q.slot[9:5] == kpsd_pkg::SLOT_RESET[9:5])
    else $error("stopped slots lost their defaults");

  a_confirm_commits: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_edit_confirm and writable) |=> commit_pulse && menu_level == kpsd_pkg::MENU_PARAM
      && param_index == $past(param_index) + 16'h0001 && commit_value == $past(edit_value))
    else $error("confirm did not commit and move on");

  a_escape_discards: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_edit_escape |=> !commit_pulse && menu_level == kpsd_pkg::MENU_PARAM
      && param_index == $past(param_index))
    else $error("escape stored or moved the parameter");

  a_blink_writable: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> value_blink == (menu_level == kpsd_pkg::MENU_EDIT && $past(writable)))
    else $error("blink does not follow writability");

  a_unchangeable_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_edit_confirm and guard.unchangeable) |=> !commit_pulse)
    else $error("unchangeable parameter was committed");

  a_stop_only_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_edit_confirm and (guard.stop_only && !guard.unchangeable && !guard.password_active))
      |=> commit_pulse == !$past(drive_running))
    else $error("stop-only parameter handled wrongly");

  a_password_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_edit_confirm and guard.password_active) |=> !commit_pulse)
    else $error("edit committed under password");

  a_verify_no_group: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && verify_menu && menu_level == kpsd_pkg::MENU_GROUP
      |=> menu_level != kpsd_pkg::MENU_GROUP)
    else $error("group menu shown in verify mode");

  a_illegal_code_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_q.aw_hold && s_q.w_hold && s_q.aw_idx == kpsd_pkg::IDX_RUN_SLOT_1
      && s_q.w_strb == 2'h3 && !legal_code(s_q.w_data)
      |=> s_q.slot[0] == $past(s_q.slot[0]) && s_axi_bresp == kpsd_pkg::RESP_SLVERR)
    else $error("illegal item code was stored");

  sequence seq_write_both;
    clk_en && s_q.aw_hold && s_q.w_hold;
  endsequence

  sequence seq_param_confirm;
    clk_en && s_q.menu == kpsd_pkg::MENU_PARAM && keys.confirm && !keys.program_escape_key
      && !(verify_menu && !param_differs);
  endsequence

  a_write_answers: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_write_both |=> s_axi_bvalid)
    else $error("write got no response");

  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  a_read_answers: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read got no data");

  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before it was taken");

  a_frozen_state: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> s_q == $past(s_q))
    else $error("state moved while the clock enable was low");

  a_edit_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_param_confirm
      |=> menu_level == kpsd_pkg::MENU_EDIT && edit_value == $past(param_value))
    else $error("confirm did not open the edit");

  a_commit_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && commit_pulse |=> !commit_pulse)
    else $error("commit pulse lasted more than one cycle");

  a_refused_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && menu_level == kpsd_pkg::MENU_EDIT && !writable && !keys.confirm
      && !keys.program_escape_key |=> edit_value == $past(edit_value))
    else $error("refused value was changed");

  a_toggle_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && s_q.run_prev != drive_running && any_nz |=> disp_item != 6'h00)
    else $error("list change landed on a disabled slot");

  a_verify_skips: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && verify_menu && menu_level == kpsd_pkg::MENU_PARAM && !keys.program_escape_key
      && !param_differs |=> param_index == $past(param_index) + 16'h0001)
    else $error("unchanged parameter was not stepped over");

endmodule

// ===== testbench/kpsd_operator.sv
`timescale 1ns/1ps
module kpsd_operator (
  input  wire logic              aresetn,
  input  wire logic              go,
  input  wire logic [4:0]        cmd,
  output kpsd_pkg::kpsd_keys_type keys
);
  // a press lasts one cycle; nothing is pressed while in reset
  assign keys = (aresetn && go) ? kpsd_pkg::kpsd_keys_type'(cmd) : '0;
endmodule

// ===== testbench/tb_keypad_status_display_select.sv
`timescale 1ns/1ps
module tb_keypad_status_display_select;
  localparam logic [4:0] K_SHIFT = 5'h10;
  localparam logic [4:0] K_CONF  = 5'h08;
  localparam logic [4:0] K_PROG  = 5'h04;
  localparam logic [4:0] K_UP    = 5'h02;
  localparam logic [4:0] K_DOWN  = 5'h01;
  logic                     aclk, aresetn, clk_en;
  logic [15:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]              s_axi_wdata, s_axi_rdata;
  logic [3:0]               s_axi_wstrb;
  logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                     s_axi_rvalid, s_axi_rready;
  logic [1:0]               s_axi_bresp, s_axi_rresp, resp;
  kpsd_pkg::kpsd_keys_type  keys;
  kpsd_pkg::kpsd_guard_type guard;
  kpsd_pkg::kpsd_menu_type  menu_level;
  logic                     drive_running, verify_menu, param_differs, value_blink;
  logic                     commit_pulse, op_go, w;
  logic [15:0]              param_value, param_index, edit_value, commit_index, commit_value;
  logic [15:0]              lfsr_q, pv;
  logic [5:0]               disp_item;
  logic [2:0]               disp_slot;
  logic [4:0]               op_cmd;
  logic [31:0]              rd;
  int                       errors, check_count, cur, idx_m;
  int                       slot_m[10] = '{5, 4, 7, 6, 8, 3, 8, 20, 26, 0};

  kpsd_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .keys(keys), .guard(guard),
    .drive_running(drive_running), .verify_menu(verify_menu), .param_differs(param_differs),
    .param_value(param_value), .disp_item(disp_item), .disp_slot(disp_slot),
    .menu_level(menu_level), .param_index(param_index), .edit_value(edit_value),
    .value_blink(value_blink), .commit_pulse(commit_pulse), .commit_index(commit_index),
    .commit_value(commit_value));

  kpsd_operator operator_i (.aresetn(aresetn), .go(op_go), .cmd(op_cmd), .keys(keys));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic bit legal(input int c);
    return c <= 20 || (c >= 25 && c <= 27) || (c >= 29 && c <= 38) || c == 40 || c == 45
        || c == 46 || c == 48 || (c >= 57 && c <= 63);
  endfunction

  function automatic int next_slot(input int c, input int base);
    int j;
    for (int k = 1; k <= 5; k++) begin
      j = (c + k) % 5;
      if (slot_m[base + j] != 0) return j;
    end
    return c;
  endfunction

  function automatic logic [15:0] slot_addr(input int i);
    return {kpsd_pkg::IDX_RUN_SLOT_1 + 14'(i), 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, wd;
    aw = 1;
    wd = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || wd) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (wd && s_axi_wready) begin
        wd = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // model tracks every accepted code; illegal ones must leave the slot alone
  task automatic wr_slot(input int i, input int c);
    axi_write(slot_addr(i), 32'(c), resp);
    chk(resp, (c < 64 && legal(c)) ? kpsd_pkg::RESP_OKAY : kpsd_pkg::RESP_SLVERR);
    if (c < 64 && legal(c)) slot_m[i] = c;
  endtask

  task automatic press(input logic [4:0] k);
    @(posedge aclk);
    op_cmd <= k;
    op_go <= 1'b1;
    @(posedge aclk);
    op_go <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    conclude();
  end

  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {drive_running, verify_menu, param_differs, op_go} = '0;
    guard = '0;
    op_cmd = '0;
    param_value = '0;
    lfsr_q = 16'hd198;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      axi_read(slot_addr(i), rd, resp);
      chk(rd, slot_m[i]);
    end
    cur = 0;
    chk(disp_item, slot_m[5]);
    for (int i = 0; i < 5; i++) begin
      press(K_SHIFT);
      cur = next_slot(cur, 5);
      chk(disp_slot, cur);
      chk(disp_item, slot_m[5 + cur]);
    end
    for (int c = 0; c <= 64; c++) wr_slot(9, c);
    for (int i = 0; i < 10; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wr_slot(i, int'(lfsr_q[5:0]));
    end
    for (int i = 0; i < 10; i++) begin
      axi_read(slot_addr(i), rd, resp);
      chk(rd, slot_m[i]);
    end
    axi_read(16'h0000, rd, resp);
    chk({rd[29:0], resp}, {30'h0, kpsd_pkg::RESP_DECERR});
    axi_write({kpsd_pkg::IDX_EDIT_STATUS, 2'b00}, 32'h0000_ffff, resp);
    chk(resp, kpsd_pkg::RESP_OKAY);
    wr_slot(0, 21);
    wr_slot(0, 0);
    wr_slot(1, 7);
    wr_slot(2, 0);
    wr_slot(3, 0);
    wr_slot(4, 19);
    @(posedge aclk);
    drive_running <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    cur = next_slot(4, 0);
    chk(disp_item, slot_m[cur]);
    for (int i = 0; i < 3; i++) begin
      press(K_SHIFT);
      cur = next_slot(cur, 0);
      chk({disp_slot, disp_item}, {3'(cur), 6'(slot_m[cur])});
    end
    idx_m = 0;
    press(K_PROG);
    chk(menu_level, kpsd_pkg::MENU_GROUP);
    press(K_UP);
    idx_m = 16'h0100;
    chk(param_index, idx_m);
    press(K_CONF);
    chk(menu_level, kpsd_pkg::MENU_PARAM);
    // every guard and run/stop combination, writable or refused
    for (int g = 0; g < 16; g++) begin
      lfsr_q = lfsr_next(lfsr_q);
      pv = lfsr_q;
      w = !g[2] && !(g[1] && g[3]) && !g[0];
      @(posedge aclk);
      guard <= 3'(g);
      drive_running <= g[3];
      param_value <= pv;
      press(K_CONF);
      chk({menu_level, edit_value}, {kpsd_pkg::MENU_EDIT, pv});
      chk(value_blink, w);
      chk(commit_pulse, 0);
      press(K_UP);
      chk(edit_value, 16'(pv + 16'(w)));
      press(K_CONF);
      chk(commit_pulse, w);
      if (w) chk({commit_index, commit_value}, {16'(idx_m), 16'(pv + 16'h0001)});
      idx_m = (idx_m + 1) & 16'hffff;
      chk({menu_level, param_index}, {kpsd_pkg::MENU_PARAM, 16'(idx_m)});
    end
    @(posedge aclk);
    guard <= '0;
    press(K_CONF);
    pv = param_value;
    press(K_DOWN);
    chk(edit_value, 16'(pv - 16'h0001));
    press(K_PROG);
    chk({menu_level, param_index}, {kpsd_pkg::MENU_PARAM, 16'(idx_m)});
    chk(commit_pulse, 0);
    press(K_PROG);
    chk(menu_level, kpsd_pkg::MENU_GROUP);
    @(posedge aclk);
    verify_menu <= 1'b1;
    param_differs <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk({menu_level, param_index}, {kpsd_pkg::MENU_PARAM, 16'(idx_m)});
    @(posedge aclk);
    param_differs <= 1'b0;
    repeat (3) @(posedge aclk);
    param_differs <= 1'b1;
    #1;
    chk(param_index, 16'(idx_m + 3));
    press(K_PROG);
    chk(menu_level, kpsd_pkg::MENU_MONITOR);
    // a frozen block must ignore keys and refuse the bus
    cur = next_slot(4, 0);
    @(posedge aclk);
    clk_en <= 1'b0;
    press(K_SHIFT);
    chk({disp_slot, s_axi_arready}, {3'(cur), 1'b0});
    @(posedge aclk);
    clk_en <= 1'b1;
    axi_read({kpsd_pkg::IDX_EDIT_STATUS, 2'b00}, rd, resp);
    chk(rd, {16'h0, 8'(idx_m + 3), 3'b110, 3'(cur), kpsd_pkg::MENU_MONITOR});
    conclude();
  end
endmodule
